// >>> rtl/pdcrc_pkg.sv
/*
  Shared constants for the dual-loop clock conditioner configuration block:
  register addresses, field positions, reset values and serial timing.
  Assumes a single 125 MHz system clock on both ends of the serial link.
*/
package pdcrc_pkg;
  localparam int unsigned CLK_NS = 8;
  // Serial clock half period in ns and in system clock cycles
  localparam int unsigned SER_HALF_NS = 32;
  localparam int unsigned SER_HALF_CYC = SER_HALF_NS / CLK_NS;
  // Length of the frequency calibration routine
  localparam int unsigned CAL_TIME_NS = 800;
  localparam int unsigned CAL_CYC = CAL_TIME_NS / CLK_NS;

  localparam logic [5:0] WORD_BITS = 6'h20;
  localparam logic [4:0] ADDR_FIRST = 5'h1b;
  localparam logic [4:0] ADDR_R12 = 5'h0c;
  localparam logic [4:0] ADDR_OUTER_PUMP_REF = 5'h1b;
  localparam logic [4:0] ADDR_INNER_REF_OUTER_FB = 5'h1c;
  localparam logic [4:0] ADDR_OSC_BAND_CAL = 5'h1d;
  localparam logic [4:0] ADDR_INNER_FB = 5'h1e;
  localparam logic [4:0] ADDR_READBACK_LOCK = 5'h1f;
  localparam int unsigned NUM_REGS = 5;

  // Register 27 fields
  localparam int unsigned OUTER_POL_BIT = 28;
  localparam int unsigned OUTER_CUR_LO = 26;
  localparam int unsigned PRESCALE_LO = 20;
  localparam int unsigned OUTER_REF_LO = 6;
  localparam int unsigned OUTER_HIZ_BIT = 5;
  // Register 28 fields
  localparam int unsigned INNER_REF_LO = 20;
  localparam int unsigned OUTER_FB_LO = 6;
  // Register 29 fields
  localparam int unsigned OSC_BAND_LO = 24;
  localparam int unsigned FAST_PD_BIT = 23;
  localparam int unsigned CAL_DIV_LO = 5;
  // Register 30 fields
  localparam int unsigned INNER_PRE_LO = 24;
  localparam int unsigned INNER_FB_LO = 5;
  // Register 31 fields
  localparam int unsigned RB_LEVEL_BIT = 21;
  localparam int unsigned RB_SEL_LO = 16;
  localparam int unsigned LOCK_BIT = 5;

  // Reset words; every divider starts at a legal ratio of one
  localparam logic [31:0] REG_RST [NUM_REGS] = '{
    32'h0000_0040, 32'h0010_0040, 32'h0000_0020, 32'h0100_0020,
    32'h0000_0000};

  // Outer pump current in microamps for codes 0 to 3
  localparam logic [10:0] CUR_UA_0 = 11'h064;
  localparam logic [10:0] CUR_UA_1 = 11'h0c8;
  localparam logic [10:0] CUR_UA_2 = 11'h190;
  localparam logic [10:0] CUR_UA_3 = 11'h640;
  localparam logic [3:0] INNER_PRE_CODE0_RATIO = 4'h8;
  localparam logic [3:0] INNER_PRE_LOW_RATIO = 4'h2;
endpackage : pdcrc_pkg

// >>> rtl/pdcrc_link_if.sv
/*
  Three-wire serial programming link with a readback line.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
interface pdcrc_link_if;
  logic ser_clk;
  logic ser_data;
  logic latch_en;
  logic rb_data;
  modport dev (input ser_clk, input ser_data, input latch_en,
    output rb_data);
  modport host (output ser_clk, output ser_data, output latch_en,
    input rb_data);
endinterface : pdcrc_link_if

// >>> rtl/pdcrc_dev.sv
/*
  Device end: serial register file for registers 27 to 31, divider and
  pump settings, frequency calibration sequencing and readback.
  Assumes link inputs synchronous to i_mclk and an external input
  switcher that reports the active clock input.
*/
// How it works
// R1 - Register 27 bit 28 sets outer pump polarity
// R2 - Pump current codes give 100/200/400/1600 microamps
// R3 - Register 27 bit 5 floats the outer pump
// R4 - Three 2-bit input prescalers in register 27
// R5 - Prescale 1/2/4/8 follows the active input
// R6 - Outer reference divider, 14 bits, never zero
// R7 - Inner reference divider, 12 bits, never zero
// R8 - Host enables doubler when inner reference is one
// R9 - Outer feedback divider in register 28, nonzero
// R10 - Host programs oscillator band; code 3 reserved
// R11 - Host sets fast flag above 100 MHz
// R12 - Calibration divider replaces feedback divider during calibration
// R13 - Register 30 write starts calibration in internal mode
// R14 - Each calibration run emits one sync event
// R15 - Inner prescaler: 0 gives 8, 1-2 give 2
// R16 - Inner feedback divider, 18 bits, never zero
// R17 - Register 31 bit 21 sets readback latch level
// R18 - Readback select picks returned register; some reserved
// R19 - Reading register 12 returns the select value
// R20 - Register 31 readback holds the lock bit and the select value in bits 4:0
// R21 - Lock bit blocks writes to registers 0-30
// R22 - Calibration starts after the whole word latched
`timescale 1ns/1ps
module pdcrc_dev (
  input wire logic i_mclk,
  input wire logic i_reset,
  pdcrc_link_if.dev link,
  input wire logic i_internal_vco_mode,
  input wire logic [1:0] i_active_input,
  output logic o_outer_pump_polarity,
  output logic [10:0] o_outer_pump_current_ua,
  output logic o_outer_pump_oe,
  output logic [3:0] o_input_prescale_ratio,
  output logic [13:0] o_outer_loop_ref_divider,
  output logic [11:0] o_inner_loop_ref_divider,
  output logic [13:0] o_outer_loop_fb_divider,
  output logic [2:0] o_osc_input_freq_band,
  output logic o_inner_fast_pd_mode,
  output logic [3:0] o_inner_loop_prescaler_ratio,
  output logic [17:0] o_inner_loop_fb_active,
  output logic o_cal_busy,
  output logic o_sync_pulse,
  output logic o_write_protect_bit
);
  typedef enum logic [0:0] {
    CAL_IDLE = 1'b0,
    CAL_RUN = 1'b1
  } pdcrc_cal_state_type;

  logic sclk_q;
  logic le_q;
  logic [31:0] shift_in_r;
  logic [5:0] bit_cnt_r;
  logic [31:0] cfg_r [pdcrc_pkg::NUM_REGS];
  logic commit_q;
  logic cal_req_r;
  pdcrc_cal_state_type cal_state_r;
  logic [15:0] cal_cnt_r;
  logic [31:0] rb_r;
  logic sclk_rise;
  logic le_rise;
  logic le_fall;
  logic commit;
  logic wr_ok;
  logic [4:0] wr_addr;
  logic [31:0] rb_word;
  logic [1:0] pre_code;
  logic [4:0] rb_sel;
  logic lock;

  assign sclk_rise = link.ser_clk & ~sclk_q;
  assign le_rise = link.latch_en & ~le_q;
  assign le_fall = ~link.latch_en & le_q;
  // A latch edge only commits after a full word, so readback framing
  // with the latch pin held high never writes stale bits
  assign commit = le_rise && (bit_cnt_r == pdcrc_pkg::WORD_BITS);
  assign wr_addr = shift_in_r[4:0];
  assign lock = cfg_r[4][pdcrc_pkg::LOCK_BIT];
  assign wr_ok = commit && (wr_addr == pdcrc_pkg::ADDR_READBACK_LOCK
    || !lock); // see R21
  assign rb_sel = cfg_r[4][pdcrc_pkg::RB_SEL_LO +: 5];
  assign link.rb_data = rb_r[31];

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      sclk_q <= 1'b0;
      le_q <= 1'b0;
    end else begin
      sclk_q <= link.ser_clk;
      le_q <= link.latch_en;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      shift_in_r <= 32'h0000_0000;
    end else if (sclk_rise) begin
      shift_in_r <= {shift_in_r[30:0], link.ser_data};
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset || le_rise || le_fall) begin
      bit_cnt_r <= 6'h00;
    end else if (sclk_rise && bit_cnt_r != pdcrc_pkg::WORD_BITS) begin
      bit_cnt_r <= bit_cnt_r + 6'h01;
    end
  end

  // Dividers and bands are stored as written; the host keeps zero out
  // of every divider and code 3 out of the band field
  generate
    for (genvar gi = 0; gi < pdcrc_pkg::NUM_REGS; gi++) begin : g_cfg
      always_ff @(posedge i_mclk) begin
        if (i_reset) begin
          cfg_r[gi] <= pdcrc_pkg::REG_RST[gi];
        end else if (wr_ok && wr_addr == pdcrc_pkg::ADDR_FIRST
            + 5'(gi)) begin
          cfg_r[gi] <= shift_in_r; // see R6 see R7 see R9 see R16
        end
      end
    end
  endgenerate

  // Request is raised on the same edge that stores the word, so the routine
  // always runs on the new prescaler and divider values
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      commit_q <= 1'b0;
      cal_req_r <= 1'b0;
    end else begin
      commit_q <= commit;
      cal_req_r <= wr_ok && i_internal_vco_mode
        && wr_addr == pdcrc_pkg::ADDR_INNER_FB; // see R13 see R22
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      cal_state_r <= CAL_IDLE;
      cal_cnt_r <= 16'h0000;
      o_sync_pulse <= 1'b0;
    end else begin
      o_sync_pulse <= cal_req_r; // see R14
      case (cal_state_r)
        CAL_IDLE: begin
          if (cal_req_r) begin
            cal_state_r <= CAL_RUN;
            cal_cnt_r <= 16'(pdcrc_pkg::CAL_CYC - 1);
          end
        end
        CAL_RUN: begin
          // A new register 30 write restarts the routine
          if (cal_req_r) begin
            cal_cnt_r <= 16'(pdcrc_pkg::CAL_CYC - 1);
          end else if (cal_cnt_r == 16'h0000) begin
            cal_state_r <= CAL_IDLE;
          end else begin
            cal_cnt_r <= cal_cnt_r - 16'h0001;
          end
        end
        default: cal_state_r <= CAL_IDLE;
      endcase
    end
  end

  always_comb begin
    rb_word = 32'h0000_0000;
    if (rb_sel == pdcrc_pkg::ADDR_R12) begin
      rb_word[pdcrc_pkg::RB_SEL_LO +: 5] = rb_sel; // see R19
    end else if (rb_sel == pdcrc_pkg::ADDR_READBACK_LOCK) begin
      rb_word[pdcrc_pkg::LOCK_BIT] = lock; // see R20
      rb_word[4:0] = rb_sel;
    end else if (rb_sel >= pdcrc_pkg::ADDR_FIRST) begin
      rb_word = cfg_r[3'(rb_sel - pdcrc_pkg::ADDR_FIRST)]; // see R18
    end
  end

  // Readback shifts only while the latch pin sits at the chosen level
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      rb_r <= 32'h0000_0000;
    end else if (commit_q) begin
      rb_r <= rb_word; // see R18
    end else if (sclk_rise
        && link.latch_en == cfg_r[4][pdcrc_pkg::RB_LEVEL_BIT]) begin
      rb_r <= {rb_r[30:0], 1'b0}; // see R17
    end
  end

  always_comb begin
    case (i_active_input)
      2'h1: pre_code = cfg_r[0][pdcrc_pkg::PRESCALE_LO + 2 +: 2];
      2'h2: pre_code = cfg_r[0][pdcrc_pkg::PRESCALE_LO + 4 +: 2];
      default: pre_code = cfg_r[0][pdcrc_pkg::PRESCALE_LO +: 2];
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_outer_pump_polarity <= 1'b0;
      o_outer_pump_current_ua <= 11'h000;
      o_outer_pump_oe <= 1'b0;
      o_input_prescale_ratio <= 4'h1;
      o_outer_loop_ref_divider <= 14'h0001;
      o_outer_loop_fb_divider <= 14'h0001;
      o_inner_loop_ref_divider <= 12'h001;
      o_osc_input_freq_band <= 3'h0;
      o_inner_fast_pd_mode <= 1'b0;
      o_write_protect_bit <= 1'b0;
    end else begin
      o_outer_pump_polarity <= cfg_r[0][pdcrc_pkg::OUTER_POL_BIT]; // see R1
      o_outer_pump_oe <= ~cfg_r[0][pdcrc_pkg::OUTER_HIZ_BIT]; // see R3
      if (cfg_r[0][pdcrc_pkg::OUTER_HIZ_BIT]) begin
        o_outer_pump_current_ua <= 11'h000; // see R2
      end else begin
        case (cfg_r[0][pdcrc_pkg::OUTER_CUR_LO +: 2])
          2'h0: o_outer_pump_current_ua <= pdcrc_pkg::CUR_UA_0;
          2'h1: o_outer_pump_current_ua <= pdcrc_pkg::CUR_UA_1;
          2'h2: o_outer_pump_current_ua <= pdcrc_pkg::CUR_UA_2;
          default: o_outer_pump_current_ua <= pdcrc_pkg::CUR_UA_3; // see R2
        endcase
      end
      o_input_prescale_ratio <= 4'h1 << pre_code; // see R4 see R5
      o_outer_loop_ref_divider <= cfg_r[0][pdcrc_pkg::OUTER_REF_LO +: 14];
      o_outer_loop_fb_divider <= cfg_r[1][pdcrc_pkg::OUTER_FB_LO +: 14];
      o_inner_loop_ref_divider <= cfg_r[1][pdcrc_pkg::INNER_REF_LO +: 12];
      o_osc_input_freq_band <= cfg_r[2][pdcrc_pkg::OSC_BAND_LO +: 3]; // see R10
      o_inner_fast_pd_mode <= cfg_r[2][pdcrc_pkg::FAST_PD_BIT];
      o_write_protect_bit <= lock;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_inner_loop_prescaler_ratio <= 4'h2;
      o_inner_loop_fb_active <= 18'h00001;
      o_cal_busy <= 1'b0;
    end else begin
      case (cfg_r[3][pdcrc_pkg::INNER_PRE_LO +: 3])
        3'h0: o_inner_loop_prescaler_ratio <=
          pdcrc_pkg::INNER_PRE_CODE0_RATIO; // see R15
        3'h1, 3'h2: o_inner_loop_prescaler_ratio <=
          pdcrc_pkg::INNER_PRE_LOW_RATIO;
        default: o_inner_loop_prescaler_ratio <=
          {1'b0, cfg_r[3][pdcrc_pkg::INNER_PRE_LO +: 3]};
      endcase
      o_cal_busy <= cal_state_r == CAL_RUN;
      if (cal_state_r == CAL_RUN) begin
        o_inner_loop_fb_active <=
          cfg_r[2][pdcrc_pkg::CAL_DIV_LO +: 18]; // see R12
      end else begin
        o_inner_loop_fb_active <= cfg_r[3][pdcrc_pkg::INNER_FB_LO +: 18];
      end
    end
  end
endmodule : pdcrc_dev

// >>> rtl/pdcrc_host.sv
/*
  Host end: turns one command word into a serial write, or clocks a
  32-bit readback with the latch pin held at the configured level.
  Assumes the same system clock as the device end.
*/
`timescale 1ns/1ps
module pdcrc_host (
  input wire logic i_mclk,
  input wire logic i_reset,
  pdcrc_link_if.host link,
  input wire logic i_cmd_valid,
  input wire logic i_cmd_read,
  input wire logic [31:0] i_cmd_word,
  input wire logic i_rb_level,
  output logic o_cmd_ready,
  output logic o_rd_valid,
  output logic [31:0] o_rd_data
);
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_LOW = 3'b001,
    H_HIGH = 3'b010,
    H_LATCH = 3'b011,
    H_GAP = 3'b100
  } pdcrc_host_state_type;

  pdcrc_host_state_type state_r;
  logic [31:0] word_r;
  logic [31:0] rd_sh_r;
  logic [4:0] bits_r;
  logic [7:0] tmr_r;
  logic read_r;
  logic sclk_r;
  logic data_r;
  logic le_r;
  logic tmr_done;

  // Host keeps dividers nonzero, band code 3 unused, fast flag and the
  // doubler consistent with its frequency plan; see R6 R7 R8 R10 R11
  assign tmr_done = tmr_r == 8'(pdcrc_pkg::SER_HALF_CYC - 1);
  assign link.ser_clk = sclk_r;
  assign link.ser_data = data_r;
  assign link.latch_en = le_r;

  always_ff @(posedge i_mclk) begin
    if (i_reset || state_r == H_IDLE || tmr_done) begin
      tmr_r <= 8'h00;
    end else begin
      tmr_r <= tmr_r + 8'h01;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      state_r <= H_IDLE;
      word_r <= 32'h0000_0000;
      rd_sh_r <= 32'h0000_0000;
      bits_r <= 5'h00;
      read_r <= 1'b0;
      sclk_r <= 1'b0;
      data_r <= 1'b0;
      le_r <= 1'b0;
      o_cmd_ready <= 1'b0;
      o_rd_valid <= 1'b0;
      o_rd_data <= 32'h0000_0000;
    end else begin
      o_rd_valid <= 1'b0;
      case (state_r)
        H_IDLE: begin
          o_cmd_ready <= 1'b1;
          if (i_cmd_valid && o_cmd_ready) begin
            o_cmd_ready <= 1'b0;
            read_r <= i_cmd_read;
            word_r <= i_cmd_read ? 32'h0000_0000 : i_cmd_word;
            data_r <= i_cmd_read ? 1'b0 : i_cmd_word[31];
            le_r <= i_cmd_read & i_rb_level; // see R17
            bits_r <= 5'h00;
            state_r <= H_LOW;
          end
        end
        H_LOW: begin
          if (tmr_done) begin
            sclk_r <= 1'b1;
            rd_sh_r <= {rd_sh_r[30:0], link.rb_data};
            state_r <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (tmr_done) begin
            sclk_r <= 1'b0;
            bits_r <= bits_r + 5'h01;
            if (bits_r == 5'h1f) begin
              // Readback adds no latch pulse after the bits; a latch held high rose at bit count zero, so nothing is written
              le_r <= ~read_r;
              state_r <= read_r ? H_GAP : H_LATCH;
            end else begin
              word_r <= {word_r[30:0], 1'b0};
              data_r <= word_r[30];
              state_r <= H_LOW;
            end
          end
        end
        H_LATCH: begin
          if (tmr_done) begin
            le_r <= 1'b0;
            state_r <= H_GAP;
          end
        end
        H_GAP: begin
          le_r <= 1'b0;
          if (tmr_done) begin
            state_r <= H_IDLE;
            o_rd_valid <= read_r;
            if (read_r) begin
              o_rd_data <= rd_sh_r; // see R20
            end
          end
        end
        default: state_r <= H_IDLE;
      endcase
    end
  end
endmodule : pdcrc_host

// >>> bench/pdcrc_link_sva.sv
/*
  Assertions on the serial link and the device end's setting outputs.
  Assumes one clock, i_mclk, and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module pdcrc_link_sva (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic ser_clk,
  input wire logic latch_en,
  input wire logic o_outer_pump_oe,
  input wire logic [10:0] o_outer_pump_current_ua,
  input wire logic [3:0] o_input_prescale_ratio,
  input wire logic [3:0] o_inner_loop_prescaler_ratio,
  input wire logic o_cal_busy,
  input wire logic o_sync_pulse
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  logic [7:0] busy_cnt_r;
  logic [7:0] since_le_r;
  // Both counters saturate so a long idle stretch cannot wrap to a pass
  always_ff @(posedge i_mclk) begin
    if (i_reset) busy_cnt_r <= 8'h00;
    // Cleared at the sync pulse, so it ends holding the busy cycle count
    else if (o_sync_pulse) busy_cnt_r <= 8'h00;
    else if (o_cal_busy && busy_cnt_r != 8'hff)
      busy_cnt_r <= busy_cnt_r + 8'h01;
  end
  always_ff @(posedge i_mclk) begin
    if (i_reset) since_le_r <= 8'hff;
    else if ($rose(latch_en)) since_le_r <= 8'h00;
    else if (since_le_r != 8'hff) since_le_r <= since_le_r + 8'h01;
  end
  // The sync pulse leads the busy flag by one cycle
  sequence cal_begin;
    o_sync_pulse ##1 o_cal_busy;
  endsequence
  sequence sclk_high;
    ser_clk [*4] ##1 !ser_clk;
  endsequence
  pump_hiz_a: assert property (
    !o_outer_pump_oe |-> o_outer_pump_current_ua == 11'h000)
    else $error("pump current nonzero while floating");
  pump_cur_a: assert property (
    o_outer_pump_oe |-> o_outer_pump_current_ua inside {11'h064, 11'h0c8,
    11'h190, 11'h640}) else $error("pump current outside its table");
  prescale_a: assert property (
    !$past(i_reset) |-> o_input_prescale_ratio inside {4'h1, 4'h2, 4'h4, 4'h8})
    else $error("input prescale ratio illegal");
  inner_pre_a: assert property (
    !$past(i_reset) |-> o_inner_loop_prescaler_ratio inside {[4'h2:4'h8]})
    else $error("inner prescaler ratio illegal");
  cal_sync_a: assert property (
    o_sync_pulse |-> cal_begin) else $error("sync without calibration");
  cal_rise_a: assert property (
    $rose(o_cal_busy) |-> $past(o_sync_pulse))
    else $error("calibration without sync");
  cal_len_a: assert property (
    $fell(o_cal_busy) |-> busy_cnt_r == pdcrc_pkg::CAL_CYC)
    else $error("calibration length wrong");
  sclk_width_a: assert property (
    $rose(ser_clk) |-> sclk_high) else $error("serial clock high time wrong");
  cal_after_le_a: assert property (
    o_sync_pulse |-> since_le_r inside {[8'h01:8'h08]})
    else $error("calibration began without a latched word");
endmodule : pdcrc_link_sva

// >>> bench/tb_pll_divider_cal_readback_cfg.sv
/*
  Self-checking bench: the host end programs the device end over the link.
  Assumes the package, interface, both ends and the checker compile first.
*/
`timescale 1ns/1ps
module tb_pll_divider_cal_readback_cfg;
  logic i_mclk = 1'b0;
  logic i_reset = 1'b1;
  logic vco_mode = 1'b1;
  logic [1:0] act_in = 2'h0;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic [31:0] cmd_word = 32'h0000_0000;
  logic rb_level = 1'b0;
  logic lk = 1'b0;
  logic cmd_ready, rd_valid, pol, pump_oe, fast_pd, cal_busy, sync_p, wp;
  logic [31:0] rd_data, rdat;
  logic [10:0] cur_ua;
  logic [3:0] pre_ratio, inner_ratio;
  logic [13:0] outer_ref, outer_fb;
  logic [11:0] inner_ref;
  logic [2:0] band;
  logic [17:0] fb_act;
  int err_total = 0;
  int check_count = 0;
  int sync_cnt = 0;
  int n, s0;
  logic [10:0] cur_tab [4] = '{pdcrc_pkg::CUR_UA_0, pdcrc_pkg::CUR_UA_1,
    pdcrc_pkg::CUR_UA_2, pdcrc_pkg::CUR_UA_3};
  logic [2:0] bands [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
  pdcrc_link_if link ();
  pdcrc_dev pdcrc_dev_inst (.i_mclk(i_mclk), .i_reset(i_reset), .link(link),
    .i_internal_vco_mode(vco_mode), .i_active_input(act_in),
    .o_outer_pump_polarity(pol), .o_outer_pump_current_ua(cur_ua),
    .o_outer_pump_oe(pump_oe), .o_input_prescale_ratio(pre_ratio),
    .o_outer_loop_ref_divider(outer_ref), .o_inner_loop_ref_divider(inner_ref),
    .o_outer_loop_fb_divider(outer_fb), .o_osc_input_freq_band(band),
    .o_inner_fast_pd_mode(fast_pd), .o_inner_loop_prescaler_ratio(inner_ratio),
    .o_inner_loop_fb_active(fb_act), .o_cal_busy(cal_busy),
    .o_sync_pulse(sync_p), .o_write_protect_bit(wp));
  pdcrc_host pdcrc_host_inst (.i_mclk(i_mclk), .i_reset(i_reset), .link(link),
    .i_cmd_valid(cmd_valid), .i_cmd_read(cmd_read), .i_cmd_word(cmd_word),
    .i_rb_level(rb_level), .o_cmd_ready(cmd_ready), .o_rd_valid(rd_valid),
    .o_rd_data(rd_data));
  pdcrc_link_sva pdcrc_link_sva_inst (.i_mclk(i_mclk), .i_reset(i_reset),
    .ser_clk(link.ser_clk), .latch_en(link.latch_en),
    .o_outer_pump_oe(pump_oe), .o_outer_pump_current_ua(cur_ua),
    .o_input_prescale_ratio(pre_ratio),
    .o_inner_loop_prescaler_ratio(inner_ratio), .o_cal_busy(cal_busy),
    .o_sync_pulse(sync_p));
  always #4 i_mclk = ~i_mclk;
  // Counted on the falling edge, where the pulse has settled
  always @(negedge i_mclk) begin
    if (sync_p === 1'b1) sync_cnt++;
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One command; returns once the host is idle again
  task cmd(input logic rd, input logic [31:0] w);
    n = 0;
    while (cmd_ready !== 1'b1 && n < 2000) begin
      @(negedge i_mclk);
      n++;
    end
    cmd_read = rd;
    cmd_word = w;
    cmd_valid = 1'b1;
    @(negedge i_mclk);
    cmd_valid = 1'b0;
    n = 0;
    do begin
      @(negedge i_mclk);
      n++;
      if (rd_valid === 1'b1) rdat = rd_data;
    end while (cmd_ready !== 1'b1 && n < 2000);
  endtask : cmd
  function automatic logic [31:0] w31(input logic lv, input logic [4:0] s);
    return {10'h000, lv, s, 10'h000, lk, pdcrc_pkg::ADDR_READBACK_LOCK};
  endfunction : w31
  task rd(input logic lv, input logic [4:0] s);
    cmd(1'b0, w31(lv, s));
    rb_level = lv;
    cmd(1'b1, 32'h0000_0000);
  endtask : rd
  task end_of_test;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (40000) @(posedge i_mclk);
    err_total++;
    end_of_test;
  end
  initial begin
    repeat (12) @(negedge i_mclk);
    i_reset = 1'b0;
    repeat (2) @(negedge i_mclk);
    for (int a = 0; a < 4; a++) begin
      rd(1'b0, 5'h1b + 5'(a));
      chk("reset word", rdat, pdcrc_pkg::REG_RST[a]);
    end
    for (int c = 0; c < 4; c++) begin
      cmd(1'b0, {3'h0, c[0], c[1:0], 2'(c + 2), 2'(c + 1), c[1:0],
        14'h3fff, 1'b0, 5'h1b});
      chk("polarity", pol, c[0]);
      chk("pump current", cur_ua, cur_tab[c]);
      chk("pump oe", pump_oe, 1'b1);
      chk("ref divider", outer_ref, 14'h3fff);
      for (int i = 0; i < 3; i++) begin
        act_in = 2'(i);
        repeat (2) @(negedge i_mclk);
        chk("prescale", pre_ratio, 4'h1 << ((c + i) % 4));
      end
    end
    cmd(1'b0, {3'h0, 1'b0, 2'h3, 6'h00, 14'h0001, 1'b1, 5'h1b});
    chk("pump oe hiz", pump_oe, 1'b0);
    chk("pump current hiz", cur_ua, 11'h000);
    chk("ref divider", outer_ref, 14'h0001);
    cmd(1'b0, {12'hfff, 14'h0fff, 1'b0, 5'h1c});
    chk("inner ref", inner_ref, 12'hfff);
    chk("outer fb", outer_fb, 14'h0fff);
    cmd(1'b0, {12'h001, 14'h0001, 1'b0, 5'h1c});
    chk("inner ref", inner_ref, 12'h001);
    chk("outer fb", outer_fb, 14'h0001);
    for (int k = 0; k < 4; k++) begin
      cmd(1'b0, {5'h00, bands[k], k[0], 18'h3ffff, 5'h1d});
      chk("osc band", band, bands[k]);
      chk("fast pd", fast_pd, k[0]);
    end
    for (int p = 0; p < 8; p++) begin
      s0 = sync_cnt;
      cmd(1'b0, {5'h00, 3'(p), 1'b0, 18'(p + 5), 5'h1e});
      chk("inner pre", inner_ratio, (p == 0) ? 8 : (p < 3) ? 2 : p);
      chk("cal busy", cal_busy, 1'b1);
      chk("one sync", sync_cnt - s0, 1);
      chk("cal divider", fb_act, 18'h3ffff);
      n = 0;
      while (cal_busy !== 1'b0 && n < 300) begin
        @(negedge i_mclk);
        n++;
      end
      chk("fb divider", fb_act, 18'(p + 5));
    end
    vco_mode = 1'b0;
    s0 = sync_cnt;
    cmd(1'b0, {5'h00, 3'h4, 1'b0, 18'h00077, 5'h1e});
    chk("no cal", cal_busy, 1'b0);
    chk("no sync", sync_cnt - s0, 0);
    chk("fb direct", fb_act, 18'h00077);
    rd(1'b1, 5'h0c);
    chk("select echo", rdat[20:16], 5'h0c);
    rd(1'b1, 5'h09);
    chk("reserved code", rdat, 32'h0000_0000);
    rd(1'b0, 5'h1e);
    chk("reg30 word", rdat[31:5], {5'h00, 3'h4, 1'b0, 18'h00077});
    lk = 1'b1;
    rd(1'b0, 5'h1c);
    chk("wp bit", wp, 1'b1);
    cmd(1'b0, {12'h0aa, 14'h0055, 1'b0, 5'h1c});
    chk("locked inner ref", inner_ref, 12'h001);
    cmd(1'b1, 32'h0000_0000);
    chk("read locked", rdat[31:5], {12'h001, 14'h0001, 1'b0});
    rd(1'b0, 5'h1f);
    chk("lock readback", rdat[5], 1'b1);
    lk = 1'b0;
    rd(1'b0, 5'h1c);
    chk("wp clear", wp, 1'b0);
    cmd(1'b0, {12'h0aa, 14'h0055, 1'b0, 5'h1c});
    chk("unlocked inner ref", inner_ref, 12'h0aa);
    cmd(1'b0, {27'h5555555, 5'h05});
    cmd(1'b1, 32'h0000_0000);
    chk("unmapped write", rdat[31:5], {12'h0aa, 14'h0055, 1'b0});
    end_of_test;
  end
endmodule : tb_pll_divider_cal_readback_cfg
